// *** hw/lhc_command_handler.sv ***
// host command decoder and executor of the data logger
// assumes a byte-level serial framer on ref_clk in front of it and a
// page memory whose read data answers memAddr in the same cycle
//
// Behaviour
// - page read: opcode, address high then low
// - async: transmit stops after page and checksum
// - sync: wrap to page start, keep sending
// - spec test: four low pulses, half-second spacing
// - pick indicator by limits-hit history
// - spec test ignored while start button low
// - read-data starts on-demand conversion when idle
// - convert only channels whose select bits set
// - done flag low pending, high when valid
// - read-data ignored during running mission
// - clear acts only with clear permit set
// - completed clear sets memory wiped flag
// - clear only while oscillator runs
// - device unavailable 500 us after clear
// - unknown opcodes do nothing
// - async checksum x16+x15+x2+1, msb first
// - 32-byte pages, async read ends at boundary
// - sync link reset abandons the read
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module lhc_command_handler #(
    parameter int LOCKOUT_CYCLES = lhc_pkg::LOCKOUT_CYCLES,
    parameter int PULSE_TICKS = lhc_pkg::PULSE_TICKS,
    parameter int PERIOD_TICKS = lhc_pkg::PERIOD_TICKS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // apb slave
    input wire lhc_pkg::lhc_apb_req_t apbReq,
    output lhc_pkg::lhc_apb_rsp_t apbRsp,
    // byte link from and to the framer
    input wire logic rxValid,
    input wire logic [7:0] rxByte,
    output logic rxReady,
    output logic txValid,
    output logic [7:0] txByte,
    input wire logic txReady,
    input wire logic syncMode,
    input wire logic linkAbort,
    // page memory read port
    output logic [15:0] memAddr,
    input wire logic [7:0] memData,
    // converter and memory engines
    input wire logic missionRunning,
    input wire logic limitsHit,
    output logic convStart,
    output logic [3:0] convChannels,
    output logic convOnDemand,
    input wire logic convDone,
    output logic clearStart,
    input wire logic clearDone,
    // pins
    input wire logic startButtonPin,
    input wire logic oscRunningPin,
    input wire logic oscTickPin,
    output logic withinLimitsIndicator_n,
    output logic limitsExceededIndicator_n
);
    // ******************************************************
    // elaboration checks
    // ******************************************************
    if (LOCKOUT_CYCLES < 8 || LOCKOUT_CYCLES > 131072) begin : g_badLock
        $error("lockout count out of range");
    end
    if (PULSE_TICKS < 1 || PULSE_TICKS >= PERIOD_TICKS ||
        PERIOD_TICKS > 65536) begin : g_badTrain
        $error("pulse train counts out of range");
    end

    // ******************************************************
    // state
    // ******************************************************
    lhc_pkg::lhc_state_t q;
    lhc_pkg::lhc_state_t d;
    logic setup;
    logic access;
    logic mapped;
    logic tickEdge;
    logic [15:0] crcNext;

    // checksum over one byte, lsb shifted in first
    function automatic logic [15:0] crcByte(input logic [15:0] c,
                                            input logic [7:0] b);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[15] ^ b[i];
            r = {r[14:0], 1'b0};
            if (fb) begin
                r = r ^ lhc_pkg::CRC_POLY;
            end
        end
        return r;
    endfunction : crcByte

    // bus decode, zero wait states since read data loads in setup
    assign setup = apbReq.psel && !apbReq.penable;
    assign access = apbReq.psel && apbReq.penable;
    assign mapped = (apbReq.paddr == lhc_pkg::REG_CTRL1) ||
                    (apbReq.paddr == lhc_pkg::REG_CTRL2) ||
                    (apbReq.paddr == lhc_pkg::REG_STATUS);
    assign tickEdge = q.tick2 && !q.tick3;
    assign crcNext = crcByte(q.crc, q.txByte);

    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        d = q;
        d.convStart = 1'b0;
        d.clearStart = 1'b0;
        // pin synchronisers, first stage feeds only the second
        d.btn1 = startButtonPin;
        d.btn2 = q.btn1;
        d.osc1 = oscRunningPin;
        d.osc2 = q.osc1;
        d.tick1 = oscTickPin;
        d.tick2 = q.tick1;
        d.tick3 = q.tick2;
        // pulse train advances on oscillator ticks only
        if (q.trainOn && tickEdge) begin
            if (q.tickCnt == 16'(PERIOD_TICKS - 1)) begin
                d.tickCnt = 16'h0000;
                d.pulses = q.pulses - 3'h1;
                d.trainOn = (q.pulses != 3'h1);
            end else begin
                d.tickCnt = q.tickCnt + 16'h0001;
            end
        end
        if (convDone) begin
            d.done = 1'b1;
        end
        if (clearDone) begin
            d.wiped = 1'b1;
        end
        // command sequencer
        case (q.state)
            lhc_pkg::S_IDLE: begin
                if (rxValid) begin
                    if (rxByte == lhc_pkg::OP_PAGE_READ) begin
                        d.state = lhc_pkg::S_ADRH;
                    end else if (rxByte == lhc_pkg::OP_SPEC_TEST) begin
                        if (q.btn2) begin
                            d.trainOn = 1'b1;
                            d.outSel = limitsHit;
                            d.pulses = lhc_pkg::TRAIN_PULSES;
                            d.tickCnt = 16'h0000;
                        end
                    end else if (rxByte == lhc_pkg::OP_READ_DATA) begin
                        if (!missionRunning) begin
                            d.convStart = 1'b1;
                            d.convCh = q.chSel;
                            d.done = 1'b0;
                        end
                    end else if (rxByte == lhc_pkg::OP_CLEAR_MEM) begin
                        d.clearStart = q.permit && q.osc2;
                        d.lockCnt = 17'h0_0000;
                        d.state = lhc_pkg::S_LOCK;
                    end
                    // any other byte falls through untouched
                end
            end
            lhc_pkg::S_ADRH: begin
                if (rxValid) begin
                    d.addr[15:8] = rxByte;
                    d.state = lhc_pkg::S_ADRL;
                end
            end
            lhc_pkg::S_ADRL: begin
                if (rxValid) begin
                    d.addr[7:0] = rxByte;
                    d.crc = lhc_pkg::CRC_INIT;
                    d.state = lhc_pkg::S_FETCH;
                end
            end
            lhc_pkg::S_FETCH: begin
                d.txByte = memData;
                d.state = lhc_pkg::S_SEND;
            end
            lhc_pkg::S_SEND: begin
                if (txReady) begin
                    d.crc = crcNext;
                    if (q.addr[4:0] == lhc_pkg::PAGE_LAST) begin
                        if (syncMode) begin
                            d.addr[4:0] = 5'h00;
                            d.state = lhc_pkg::S_FETCH;
                        end else begin
                            d.txByte = crcNext[15:8];
                            d.state = lhc_pkg::S_CRCH;
                        end
                    end else begin
                        d.addr = q.addr + 16'h0001;
                        d.state = lhc_pkg::S_FETCH;
                    end
                end
            end
            lhc_pkg::S_CRCH: begin
                if (txReady) begin
                    d.txByte = q.crc[7:0];
                    d.state = lhc_pkg::S_CRCL;
                end
            end
            lhc_pkg::S_CRCL: begin
                if (txReady) begin
                    d.state = lhc_pkg::S_IDLE;
                end
            end
            lhc_pkg::S_LOCK: begin
                // bytes are accepted and thrown away here
                if (q.lockCnt == 17'(LOCKOUT_CYCLES - 1)) begin
                    d.state = lhc_pkg::S_IDLE;
                end else begin
                    d.lockCnt = q.lockCnt + 17'h0_0001;
                end
            end
            default: begin
                d.state = lhc_pkg::S_IDLE;
            end
        endcase
        // the sync link reset drops a read in any phase
        if (syncMode && linkAbort &&
            q.state != lhc_pkg::S_IDLE && q.state != lhc_pkg::S_LOCK) begin
            d.state = lhc_pkg::S_IDLE;
        end
        // selected indicator low during the first part of each period
        d.withinN = !(d.trainOn && !d.outSel &&
                      d.tickCnt < 16'(PULSE_TICKS));
        d.exceededN = !(d.trainOn && d.outSel &&
                        d.tickCnt < 16'(PULSE_TICKS));
        // register reads prepared in setup
        d.prdata = 32'h0000_0000;
        if (setup) begin
            if (apbReq.paddr == lhc_pkg::REG_CTRL1) begin
                d.prdata[lhc_pkg::CTRL1_PERMIT] = q.permit;
            end else if (apbReq.paddr == lhc_pkg::REG_CTRL2) begin
                d.prdata[lhc_pkg::CTRL2_SEL_LSB +: 4] = q.chSel;
            end else if (apbReq.paddr == lhc_pkg::REG_STATUS) begin
                d.prdata[lhc_pkg::STAT_DONE] = q.done;
                d.prdata[lhc_pkg::STAT_WIPED] = q.wiped;
                d.prdata[lhc_pkg::STAT_MISSION] = missionRunning;
                d.prdata[lhc_pkg::STAT_BUSY] = q.state != lhc_pkg::S_IDLE;
            end
        end
        // register writes at the access edge
        if (access && apbReq.pwrite) begin
            if (apbReq.paddr == lhc_pkg::REG_CTRL1) begin
                d.permit = apbReq.pwdata[lhc_pkg::CTRL1_PERMIT];
            end else if (apbReq.paddr == lhc_pkg::REG_CTRL2) begin
                d.chSel = apbReq.pwdata[lhc_pkg::CTRL2_SEL_LSB +: 4];
            end else if (apbReq.paddr == lhc_pkg::REG_STATUS) begin
                // write one clears, a same-cycle set still wins
                if (apbReq.pwdata[lhc_pkg::STAT_WIPED] && !clearDone) begin
                    d.wiped = 1'b0;
                end
            end
        end
    end

    // ******************************************************
    // registers
    // ******************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{state: lhc_pkg::S_IDLE, permit: lhc_pkg::CTRL1_RESET,
                   chSel: lhc_pkg::CTRL2_RESET, done: lhc_pkg::DONE_RESET,
                   withinN: 1'b1, exceededN: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // outputs
    // one driver for the whole response word
    assign apbRsp = '{pready: 1'b1, pslverr: access && !mapped,
                      prdata: q.prdata};
    assign rxReady = (q.state == lhc_pkg::S_IDLE) ||
                     (q.state == lhc_pkg::S_ADRH) ||
                     (q.state == lhc_pkg::S_ADRL) ||
                     (q.state == lhc_pkg::S_LOCK);
    assign txValid = (q.state == lhc_pkg::S_SEND) ||
                     (q.state == lhc_pkg::S_CRCH) ||
                     (q.state == lhc_pkg::S_CRCL);
    assign txByte = q.txByte;
    assign memAddr = q.addr;
    assign convStart = q.convStart;
    assign convChannels = q.convCh;
    assign convOnDemand = q.convStart;
    assign clearStart = q.clearStart;
    assign withinLimitsIndicator_n = q.withinN;
    assign limitsExceededIndicator_n = q.exceededN;

    // ******************************************************
    // assertions
    // ******************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_pageEnd;
        q.state == lhc_pkg::S_SEND && txReady && !syncMode &&
        !linkAbort && q.addr[4:0] == lhc_pkg::PAGE_LAST
        |=> q.state == lhc_pkg::S_CRCH ##1 txValid;
    endproperty
    a_pageEnd: assert property (p_pageEnd)
        else $error("async page end did not go to checksum");

    property p_wrap;
        q.state == lhc_pkg::S_SEND && txReady && syncMode && !linkAbort &&
        q.addr[4:0] == lhc_pkg::PAGE_LAST
        |=> q.addr[4:0] == 5'h00 && q.addr[15:5] == $past(q.addr[15:5]);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("sync read did not wrap to page start");

    property p_txStop;
        q.state == lhc_pkg::S_CRCL && txReady |=> !txValid;
    endproperty
    a_txStop: assert property (p_txStop)
        else $error("transmit still active after checksum");

    property p_specIgnore;
        q.state == lhc_pkg::S_IDLE && rxValid &&
        rxByte == lhc_pkg::OP_SPEC_TEST && !q.btn2 && !q.trainOn
        |=> !q.trainOn;
    endproperty
    a_specIgnore: assert property (p_specIgnore)
        else $error("spec test started with button low");

    property p_fourPulses;
        $rose(q.trainOn) |-> q.pulses == 3'h4 && q.tickCnt == 16'h0000;
    endproperty
    a_fourPulses: assert property (p_fourPulses)
        else $error("pulse train did not start with four pulses");

    property p_lowPhase;
        !withinLimitsIndicator_n || !limitsExceededIndicator_n
        |-> q.trainOn && q.tickCnt < 16'(PULSE_TICKS) &&
            (withinLimitsIndicator_n || limitsExceededIndicator_n);
    endproperty
    a_lowPhase: assert property (p_lowPhase)
        else $error("indicator low outside pulse phase");

    property p_missionBlock;
        q.state == lhc_pkg::S_IDLE && rxValid &&
        rxByte == lhc_pkg::OP_READ_DATA && missionRunning |=> !convStart;
    endproperty
    a_missionBlock: assert property (p_missionBlock)
        else $error("conversion started during mission");

    property p_donePending;
        convStart |-> !q.done;
    endproperty
    a_donePending: assert property (p_donePending)
        else $error("done flag high while conversion pending");

    // a new read-data command in the same cycle keeps the flag low
    property p_doneSet;
        convDone && !(q.state == lhc_pkg::S_IDLE && rxValid &&
        rxByte == lhc_pkg::OP_READ_DATA && !missionRunning) |=> q.done;
    endproperty
    a_doneSet: assert property (p_doneSet)
        else $error("done flag not set after conversion");

    property p_clearGate;
        clearStart |-> $past(q.permit) && $past(q.osc2);
    endproperty
    a_clearGate: assert property (p_clearGate)
        else $error("clear started without permit or oscillator");

    property p_wiped;
        clearDone |=> q.wiped;
    endproperty
    a_wiped: assert property (p_wiped)
        else $error("wiped flag not set after clear");

    property p_lockout;
        $rose(q.state == lhc_pkg::S_LOCK) |-> (q.state == lhc_pkg::S_LOCK)[*8];
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("lockout ended too early");

    property p_abort;
        syncMode && linkAbort && q.state == lhc_pkg::S_SEND
        |=> q.state == lhc_pkg::S_IDLE;
    endproperty
    a_abort: assert property (p_abort)
        else $error("link reset did not abandon read");
endmodule : lhc_command_handler

// *** hw/lhc_pkg.sv ***
// shared constants and types of the logger host command handler
// assumes a 250 MHz ref_clk and a 32768 Hz timekeeping tick input
package lhc_pkg;
    // ******************************************************
    // opcodes and page layout
    // ******************************************************
    localparam logic [7:0] OP_PAGE_READ = 8'h33;
    localparam logic [7:0] OP_SPEC_TEST = 8'h44;
    localparam logic [7:0] OP_READ_DATA = 8'h55;
    localparam logic [7:0] OP_CLEAR_MEM = 8'hA5;
    localparam int PAGE_BYTES = 32;
    localparam logic [4:0] PAGE_LAST = 5'h1F;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;

    // ******************************************************
    // apb register map and fields
    // ******************************************************
    localparam logic [11:0] REG_CTRL1 = 12'h000;
    localparam logic [11:0] REG_CTRL2 = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam int CTRL1_PERMIT = 0;
    localparam int CTRL2_SEL_LSB = 0;
    localparam int STAT_DONE = 0;
    localparam int STAT_WIPED = 1;
    localparam int STAT_MISSION = 2;
    localparam int STAT_BUSY = 3;
    localparam logic CTRL1_RESET = 1'b0;
    localparam logic [3:0] CTRL2_RESET = 4'h0;
    localparam logic DONE_RESET = 1'b0;

    // ******************************************************
    // timing
    // ******************************************************
    localparam int REF_CLK_MHZ = 250;
    localparam int LOCKOUT_US = 500;
    localparam int LOCKOUT_CYCLES = LOCKOUT_US * REF_CLK_MHZ;
    localparam int OSC_HZ = 32768;
    localparam int PULSE_TENTH_MS = 625;
    localparam int PERIOD_MS = 500;
    localparam int PULSE_TICKS = PULSE_TENTH_MS * OSC_HZ / 10000;
    localparam int PERIOD_TICKS = PERIOD_MS * OSC_HZ / 1000;
    localparam logic [2:0] TRAIN_PULSES = 3'h4;

    // ******************************************************
    // types
    // ******************************************************
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_ADRH = 8'h02,
        S_ADRL = 8'h04,
        S_FETCH = 8'h08,
        S_SEND = 8'h10,
        S_CRCH = 8'h20,
        S_CRCL = 8'h40,
        S_LOCK = 8'h80
    } lhc_state_e_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lhc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } lhc_apb_rsp_t;

    typedef struct packed {
        lhc_state_e_t state;
        logic [15:0] addr;
        logic [7:0] txByte;
        logic [15:0] crc;
        logic [16:0] lockCnt;
        logic permit;
        logic [3:0] chSel;
        logic done;
        logic wiped;
        logic convStart;
        logic [3:0] convCh;
        logic clearStart;
        logic [31:0] prdata;
        logic trainOn;
        logic outSel;
        logic [2:0] pulses;
        logic [15:0] tickCnt;
        logic withinN;
        logic exceededN;
        logic btn1;
        logic btn2;
        logic osc1;
        logic osc2;
        logic tick1;
        logic tick2;
        logic tick3;
    } lhc_state_t;
endpackage : lhc_pkg

// *** verification/lhc_host_model.sv ***
// far-side partner: page memory and a transmit framer that may stall
// assumes the handler's memAddr and tx handshake on the same ref_clk
`timescale 1ns/1ps
module lhc_host_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // memory read port and transmit side
    input wire logic [15:0] memAddr,
    output logic [7:0] memData,
    input wire logic slow,
    output logic txReady
);
    logic stallQ;
    // page contents are a fixed pattern of the address, answered at once
    assign memData = memAddr[7:0] ^ 8'h5A;
    // stall every other cycle while slow, so a byte offered on a stalled cycle is held for one more cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            stallQ <= 1'b0;
        else
            stallQ <= ~stallQ;
    end
    assign txReady = !slow || stallQ;
endmodule : lhc_host_model

// *** verification/lhc_command_handler_tb.sv ***
// self-checking bench of the logger host command handler
// assumes lhc_pkg, the handler and lhc_host_model are compiled first
`timescale 1ns/1ps
module lhc_command_handler_tb;
    logic ref_clk = 1'b0, reset_n = 1'b0, slow = 1'b1;
    lhc_pkg::lhc_apb_req_t apbReq = '0;
    lhc_pkg::lhc_apb_rsp_t apbRsp;
    logic rxValid = 1'b0, rxReady, txValid, txReady, syncMode = 1'b0;
    logic [7:0] rxByte = 8'h00, txByte, memData;
    logic linkAbort = 1'b0, missionRunning = 1'b0, limitsHit = 1'b0;
    logic convDone = 1'b0, clearDone = 1'b0, startButtonPin = 1'b1;
    logic oscRunningPin = 1'b1, oscTickPin = 1'b0, er, lastOd;
    logic convStart, convOnDemand, clearStart, withinInd_n, exceedInd_n;
    logic [3:0] convChannels, lastCh;
    logic [15:0] memAddr;
    logic [31:0] rd;
    int fails = 0, num_checks = 0, convCnt = 0, clrCnt = 0, txCnt = 0;
    int fallW = 0, fallE = 0, lowCnt = 0, c0, c1, l0;

    // ************************************************************
    // clocks, design and partner
    // ************************************************************
    always #2 ref_clk = ~ref_clk;
    // slow tick: one oscillator period every 16 ref_clk cycles
    always begin
        repeat (8) @(posedge ref_clk);
        oscTickPin <= ~oscTickPin;
    end
    lhc_command_handler #(.LOCKOUT_CYCLES(16), .PULSE_TICKS(2),
        .PERIOD_TICKS(8)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
        .apbReq(apbReq), .apbRsp(apbRsp), .rxValid(rxValid),
        .rxByte(rxByte), .rxReady(rxReady), .txValid(txValid),
        .txByte(txByte), .txReady(txReady), .syncMode(syncMode),
        .linkAbort(linkAbort), .memAddr(memAddr), .memData(memData),
        .missionRunning(missionRunning), .limitsHit(limitsHit),
        .convStart(convStart), .convChannels(convChannels),
        .convOnDemand(convOnDemand), .convDone(convDone),
        .clearStart(clearStart), .clearDone(clearDone),
        .startButtonPin(startButtonPin), .oscRunningPin(oscRunningPin),
        .oscTickPin(oscTickPin), .withinLimitsIndicator_n(withinInd_n),
        .limitsExceededIndicator_n(exceedInd_n));
    lhc_host_model host (.ref_clk(ref_clk), .reset_n(reset_n),
        .memAddr(memAddr), .memData(memData), .slow(slow),
        .txReady(txReady));
    // event counters, sampled before the edge's own updates land
    always @(posedge ref_clk) begin
        if (convStart === 1'b1) begin
            convCnt++;
            lastCh = convChannels;
            lastOd = convOnDemand;
        end
        if (clearStart === 1'b1) clrCnt++;
        if (txValid === 1'b1) txCnt++;
        if (withinInd_n === 1'b0) lowCnt++;
        if (exceedInd_n === 1'b0) lowCnt++;
    end
    always @(negedge withinInd_n) fallW++;
    always @(negedge exceedInd_n) fallE++;

    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one apb transfer, then an idle edge so calls never collide
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= w;
        apbReq.paddr <= a;
        apbReq.pwdata <= wd;
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        do @(posedge ref_clk); while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rdchk
    task automatic send(input logic [7:0] b);
        rxValid <= 1'b1;
        rxByte <= b;
        do @(posedge ref_clk); while (rxReady !== 1'b1);
        rxValid <= 1'b0;
        @(posedge ref_clk);
    endtask : send
    task automatic get_tx(input logic [7:0] e);
        int t;
        t = 0;
        do begin
            @(posedge ref_clk);
            t++;
        end while (!(txValid === 1'b1 && txReady === 1'b1) && t < 300);
        if (!(txValid === 1'b1 && txReady === 1'b1)) begin
            fails++;
            $display("ERROR at %0t: tx timeout got %h expected %h",
                $time, txByte, e);
            end_sim();
        end else begin
            check({24'h0, txByte}, {24'h0, e});
        end
    endtask : get_tx
    // page read of n bytes; async mode adds the checksum and goes quiet
    task automatic page_rd(input logic [15:0] a, input int n);
        logic [15:0] crc, ad;
        logic [7:0] b;
        crc = lhc_pkg::CRC_INIT;
        send(lhc_pkg::OP_PAGE_READ);
        send(a[15:8]);
        send(a[7:0]);
        for (int k = 0; k < n; k++) begin
            ad = {a[15:5], 5'(a[4:0] + k)};
            b = ad[7:0] ^ 8'h5A;
            get_tx(b);
            for (int i = 0; i < 8; i++)
                crc = {crc[14:0], 1'b0}
                    ^ ((crc[15] ^ b[i]) ? lhc_pkg::CRC_POLY : 16'h0000);
        end
        if (!syncMode) begin
            get_tx(crc[15:8]);
            get_tx(crc[7:0]);
            @(posedge ref_clk);
            c0 = txCnt;
            repeat (10) @(posedge ref_clk);
            check(32'(txCnt - c0), 32'h0);
        end
    endtask : page_rd
    task automatic spec(input logic btn, input logic hit, input int ew,
        input int ee);
        startButtonPin <= btn;
        limitsHit <= hit;
        repeat (4) @(posedge ref_clk);
        c0 = fallW;
        c1 = fallE;
        l0 = lowCnt;
        send(lhc_pkg::OP_SPEC_TEST);
        repeat (700) @(posedge ref_clk);
        check(32'(fallW - c0), 32'(ew));
        check(32'(fallE - c1), 32'(ee));
        check(32'((lowCnt - l0 + 16) / 32), 32'(ew + ee));
    endtask : spec
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        #100000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rdchk(lhc_pkg::REG_CTRL1, 32'h0);
        rdchk(lhc_pkg::REG_CTRL2, 32'h0);
        rdchk(lhc_pkg::REG_STATUS, 32'h0);
        rdchk(12'h010, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b1, lhc_pkg::REG_CTRL2, 32'hA);
        rdchk(lhc_pkg::REG_CTRL2, 32'hA);
        // on-demand conversion, then done flag after the engine answers
        c0 = convCnt;
        send(lhc_pkg::OP_READ_DATA);
        // let the event counter take the pulse before looking
        @(posedge ref_clk);
        check(32'(convCnt - c0), 32'h1);
        check({27'h0, lastOd, lastCh}, 32'h1A);
        rdchk(lhc_pkg::REG_STATUS, 32'h0);
        convDone <= 1'b1;
        @(posedge ref_clk);
        convDone <= 1'b0;
        rdchk(lhc_pkg::REG_STATUS, 32'h1);
        missionRunning <= 1'b1;
        send(lhc_pkg::OP_READ_DATA);
        rdchk(lhc_pkg::REG_STATUS, 32'h5);
        check(32'(convCnt - c0), 32'h1);
        missionRunning <= 1'b0;
        c0 = clrCnt;
        c1 = convCnt;
        l0 = txCnt;
        send(8'h22);
        repeat (8) @(posedge ref_clk);
        check(32'(convCnt - c1 + clrCnt - c0 + txCnt - l0), 32'h0);
        rdchk(lhc_pkg::REG_STATUS, 32'h1);
        // clear needs permit and a running oscillator
        send(lhc_pkg::OP_CLEAR_MEM);
        repeat (30) @(posedge ref_clk);
        apb(1'b1, lhc_pkg::REG_CTRL1, 32'h1);
        oscRunningPin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        send(lhc_pkg::OP_CLEAR_MEM);
        repeat (30) @(posedge ref_clk);
        check(32'(clrCnt - c0), 32'h0);
        oscRunningPin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        c1 = convCnt;
        send(lhc_pkg::OP_CLEAR_MEM);
        send(lhc_pkg::OP_READ_DATA);
        clearDone <= 1'b1;
        @(posedge ref_clk);
        clearDone <= 1'b0;
        repeat (30) @(posedge ref_clk);
        check(32'(clrCnt - c0), 32'h1);
        check(32'(convCnt - c1), 32'h0);
        rdchk(lhc_pkg::REG_STATUS, 32'h3);
        apb(1'b1, lhc_pkg::REG_STATUS, 32'h2);
        rdchk(lhc_pkg::REG_STATUS, 32'h1);
        page_rd(16'h001E, 2);
        page_rd(16'h0120, 32);
        // sync mode wraps inside the page until the link is reset
        syncMode <= 1'b1;
        page_rd(16'h003E, 5);
        // abort while the next byte is on offer
        @(posedge ref_clk);
        linkAbort <= 1'b1;
        repeat (4) @(posedge ref_clk);
        linkAbort <= 1'b0;
        rdchk(lhc_pkg::REG_STATUS, 32'h1);
        spec(1'b0, 1'b0, 0, 0);
        spec(1'b1, 1'b0, 4, 0);
        spec(1'b1, 1'b1, 0, 4);
        end_sim();
    end
endmodule : lhc_command_handler_tb
